// ---- testbench.sv ----
// self-checking bench for the two-wire serial block against a target model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import twsc_pkg::*;
	logic clk = 1'b0;
	logic rstn, ctrl_wr, data_wr, rx_ready, nack;
	twsc_ctrl_s ctrl;
	logic [7:0] data, status, dout, rx_data, t_last;
	logic done, wr_coll, rx_valid, scl_oe, sda_oe, t_oe, t_busy;
	logic [3:0] t_cnt;
	logic m_scl_oe, m_sda_oe, m_ack;
	wire logic scl;
	wire logic sda;
	int fails = 0;
	int n_checks = 0;
	int i;
	// open-drain lines with pull-ups
	assign scl = ~(scl_oe | m_scl_oe);
	assign sda = ~(sda_oe | t_oe | m_sda_oe);
	always #5 clk = ~clk;
	twsc_two_wire_serial_block #(.QTR(2), .FIFO_DEPTH(4)) DUT (
		.sys_clk_i(clk), .rstn_i(rstn), .ctrl_wr_i(ctrl_wr), .ctrl_i(ctrl),
		.data_wr_i(data_wr), .data_i(data), .own_addr_i(7'h11),
		.done_o(done), .status_o(status), .data_o(dout),
		.wr_coll_o(wr_coll), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_ready_i(rx_ready), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe)
	);
	twsc_tgt_model #(.ADDR(7'h2a), .TX(8'h3c)) tgt (
		.scl_i(scl), .sda_i(sda), .nack_i(nack), .sda_oe_o(t_oe),
		.busy_o(t_busy), .last_o(t_last), .count_o(t_cnt)
	);
	task summarize();
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cw(input logic c, input logic s, input logic p, input logic a,
		input logic e);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		ctrl <= {c, s, p, a, e};
		@(posedge clk);
		ctrl_wr <= 1'b0;
	endtask
	task dw(input logic [7:0] b);
		@(posedge clk);
		data_wr <= 1'b1;
		data <= b;
		@(posedge clk);
		data_wr <= 1'b0;
		#1;
	endtask
	task wait_done(input logic [7:0] code);
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if (done === 1'b1) break;
		end
		if (i == 4000) begin
			fails++;
			summarize();
		end
		check(status, code);
	endtask
	task wait_idle();
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if (t_busy === 1'b0) break;
		end
		if (i == 4000) begin
			fails++;
			summarize();
		end
		repeat (4) @(posedge clk);
		#1;
		check({6'h00, scl, sda}, 8'h03);
		check(8'(done), 8'h00);
	endtask
	task pop(input logic [7:0] exp);
		int k;
		for (k = 0; k < 100; k++) begin
			if (rx_valid === 1'b1) break;
			@(posedge clk);
			#1;
		end
		if (k == 100) begin
			fails++;
			summarize();
		end
		check(rx_data, exp);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
		#1;
	endtask
	// another controller on the lines, a quarter bit of four cycles
	task mwait();
		repeat (4) @(posedge clk);
	endtask
	task mclk(input logic b, output logic s);
		int k;
		m_sda_oe <= !b;
		mwait();
		m_scl_oe <= 1'b0;
		// the block may stretch the clock, so wait for the line to rise
		for (k = 0; k < 400; k++) begin
			@(posedge clk);
			if (scl === 1'b1) break;
		end
		if (k == 400) begin
			fails++;
			summarize();
		end
		mwait();
		s = sda;
		m_scl_oe <= 1'b1;
		mwait();
	endtask
	task mbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int j = 7; j >= 0; j--) begin
			mclk(b[j], s);
		end
		mclk(1'b1, ack);
	endtask
	task mstart();
		m_sda_oe <= 1'b1;
		mwait();
		m_scl_oe <= 1'b1;
		mwait();
	endtask
	task mstop();
		m_sda_oe <= 1'b1;
		mwait();
		m_scl_oe <= 1'b0;
		mwait();
		m_sda_oe <= 1'b0;
		mwait();
	endtask
	initial begin
		rstn = 1'b0;
		ctrl_wr = 1'b0;
		ctrl = '0;
		data_wr = 1'b0;
		data = 8'h00;
		rx_ready = 1'b0;
		m_scl_oe = 1'b0;
		m_sda_oe = 1'b0;
		nack = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check(8'(done), 8'h00);
		check(status, 8'hf8);
		check({6'h00, scl_oe, sda_oe}, 8'h00);
		@(posedge clk);
		rstn <= 1'b1;
		// controller send: start, address, data acked, data refused, stop
		cw(1, 1, 0, 0, 1);
		wait_done(START_CODE);
		repeat (50) @(posedge clk);
		#1;
		check(8'(done), 8'h01);
		check(8'(scl_oe), 8'h01);
		check(8'(t_cnt), 8'h00);
		dw(8'h54);
		cw(1, 0, 0, 0, 1);
		dw(8'hff);
		check(8'(wr_coll), 8'h01);
		wait_done(ADDR_WRITE_ACKED_CODE);
		check(t_last, 8'h54);
		dw(8'ha5);
		check(8'(wr_coll), 8'h00);
		cw(1, 0, 0, 0, 1);
		wait_done(DATA_WRITE_ACKED_CODE);
		check(t_last, 8'ha5);
		nack = 1'b1;
		dw(8'h0f);
		cw(1, 0, 0, 0, 1);
		wait_done(DATA_WRITE_NACK_CODE);
		nack = 1'b0;
		cw(1, 0, 1, 0, 1);
		wait_idle();
		// nobody answers this address, so the line floats high
		cw(1, 1, 0, 0, 1);
		wait_done(START_CODE);
		dw(8'h66);
		cw(1, 0, 0, 0, 1);
		wait_done(ADDR_WRITE_NACK_CODE);
		cw(1, 0, 1, 0, 1);
		wait_idle();
		// controller receive until the fifo refuses, then drain it
		cw(1, 1, 0, 0, 1);
		wait_done(START_CODE);
		dw(8'h55);
		cw(1, 0, 0, 0, 1);
		wait_done(ADDR_READ_ACKED_CODE);
		check(t_last, 8'h55);
		repeat (4) begin
			cw(1, 0, 0, 1, 1);
			wait_done(DATA_READ_ACKED_CODE);
			check(dout, 8'h3c);
		end
		cw(1, 0, 0, 0, 1);
		repeat (300) @(posedge clk);
		#1;
		check(8'(done), 8'h00);
		check(8'(scl_oe), 8'h01);
		repeat (4) pop(8'h3c);
		wait_done(DATA_READ_NACK_CODE);
		pop(8'h3c);
		cw(1, 0, 1, 0, 1);
		wait_idle();
		// another controller writes one byte to our own target address
		cw(0, 0, 0, 1, 1);
		mstart();
		mbyte(8'h22, m_ack);
		check(8'(m_ack), 8'h00);
		wait_done(TGT_WRITE_ADDR_CODE);
		check(8'(scl_oe), 8'h01);
		cw(1, 0, 0, 1, 1);
		mbyte(8'h9a, m_ack);
		check(8'(m_ack), 8'h00);
		wait_done(TGT_RX_ACK_CODE);
		pop(8'h9a);
		cw(1, 0, 0, 1, 1);
		mstop();
		wait_done(TGT_STOP_CODE);
		// start request with the interface disabled must leave the bus alone
		cw(1, 1, 0, 0, 0);
		repeat (100) @(posedge clk);
		#1;
		check(8'(done), 8'h00);
		check({6'h00, scl_oe, sda_oe}, 8'h00);
		summarize();
	end
endmodule // testbench
`default_nettype wire

// ---- twsc_fifo.sv ----
// receive byte fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module twsc_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk_i, // system clock
	input wire logic rstn_i, // sync reset, active low
	input wire logic in_valid_i, // write request
	input wire logic [W-1:0] in_data_i, // write data
	output logic in_ready_o, // room for one more word
	output logic out_valid_o, // read data valid
	output logic [W-1:0] out_data_o, // read data
	input wire logic out_ready_i // reader takes word
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wr_q, rd_q, rd_nx;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction

	assign in_ready_o = (cnt_q != (AW+1)'(D));
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign rd_nx = nxt(rd_q);
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			cnt_q <= cnt_d;
			out_valid_o <= (cnt_d != '0);
			if (push) begin
				wr_q <= nxt(wr_q);
			end
			if (pop) begin
				rd_q <= rd_nx;
			end
			// keep the head word in its own register so readers see no mux
			if (pop && cnt_q > (AW+1)'(1)) begin
				out_data_o <= mem_q[rd_nx];
			end else if (push && (pop || cnt_q == '0)) begin
				out_data_o <= in_data_i;
			end
		end
	end
endmodule // twsc_fifo
`default_nettype wire

// ---- twsc_pkg.sv ----
// constants, codes and carrier types of the two-wire serial block
// Overview of operation
// - four roles: controller send, controller receive, target send, target receive.
// - bus transfer stays suspended while done is set, until software clears it; not after lost arbitration or a target STOP.
// - status code sits in upper bits; low three bits read as zero.
// - control write with done, start and enable sends START, then done sets.
// - address plus write bit in data register, then done and enable start it.
// - after address byte and acknowledge slot, done sets; code tells ack or nack.
// - data byte in data register, then done and enable send it.
// - after data byte and acknowledge slot, done sets; code tells ack or nack.
// - direction bit is high on the data line for read, low for write.
// - low data line in acknowledge slot means ack, high means nack.
// - control write with stop, done and enable, start cleared, sends STOP.
// - after a START went out the status code is 0x08.
// - enable must be one or the block leaves the bus alone.
// - clock line held low while done is set, except after lost arbitration or a target STOP; released after it clears.
`default_nettype none
package twsc_pkg;

	localparam int SYS_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
	localparam int RX_FIFO_DEPTH = 4;
	localparam int DATA_W = 8;

	localparam logic [7:0] START_CODE = 8'h08;
	localparam logic [7:0] RESTART_CODE = 8'h10;
	localparam logic [7:0] ADDR_WRITE_ACKED_CODE = 8'h18;
	localparam logic [7:0] ADDR_WRITE_NACK_CODE = 8'h20;
	localparam logic [7:0] DATA_WRITE_ACKED_CODE = 8'h28;
	localparam logic [7:0] DATA_WRITE_NACK_CODE = 8'h30;
	localparam logic [7:0] ARB_LOST_CODE = 8'h38;
	localparam logic [7:0] ADDR_READ_ACKED_CODE = 8'h40;
	localparam logic [7:0] ADDR_READ_NACK_CODE = 8'h48;
	localparam logic [7:0] DATA_READ_ACKED_CODE = 8'h50;
	localparam logic [7:0] DATA_READ_NACK_CODE = 8'h58;
	localparam logic [7:0] TGT_WRITE_ADDR_CODE = 8'h60;
	localparam logic [7:0] TGT_RX_ACK_CODE = 8'h80;
	localparam logic [7:0] TGT_RX_NACK_CODE = 8'h88;
	localparam logic [7:0] TGT_STOP_CODE = 8'ha0;
	localparam logic [7:0] TGT_READ_ADDR_CODE = 8'ha8;
	localparam logic [7:0] TGT_TX_ACK_CODE = 8'hb8;
	localparam logic [7:0] TGT_TX_NACK_CODE = 8'hc0;
	localparam logic [7:0] NO_INFO_CODE = 8'hf8;

	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] BYTE_END = 4'h9;

	typedef enum logic [2:0] {
		TWSC_IDLE = 3'b000,
		TWSC_START = 3'b001,
		TWSC_HOLD = 3'b011,
		TWSC_SHIFT = 3'b010,
		TWSC_STOP = 3'b110
	} twsc_state_e;

	typedef struct packed {
		logic done_clr;
		logic start;
		logic stop;
		logic ack_en;
		logic enable;
	} twsc_ctrl_s;

endpackage
`default_nettype wire

// ---- twsc_tgt_model.sv ----
// behavioural two-wire target: takes writes, sends a fixed byte on reads
`timescale 1ns/1ps
`default_nettype none
module twsc_tgt_model #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] TX = 8'h3c
) (
	input wire logic scl_i, // clock line level
	input wire logic sda_i, // data line level
	input wire logic nack_i, // refuse written data bytes
	output logic sda_oe_o, // data line pulled low
	output logic busy_o, // between start and stop
	output logic [7:0] last_o, // last byte written on the bus
	output logic [3:0] count_o // bytes written on the bus
);
	int bitc = 0;
	logic [7:0] sh = 8'h00;
	logic hit = 1'b0;
	logic rd = 1'b0;
	logic first = 1'b0;
	initial begin
		sda_oe_o = 1'b0;
		busy_o = 1'b0;
		last_o = 8'h00;
		count_o = 4'h0;
	end
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			busy_o = 1'b1;
			bitc = 0;
			first = 1'b1;
			hit = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			busy_o = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		if (busy_o && bitc < 8) begin
			sh = {sh[6:0], sda_i};
			bitc++;
		end else if (bitc == 9 && rd && !first && sda_i) begin
			hit = 1'b0;
		end
	end
	// changes only while the clock is low, so a start or stop is never faked
	always @(negedge scl_i) begin
		if (busy_o && bitc == 8) begin
			if (first) begin
				hit = (sh[7:1] == ADDR);
				rd = sh[0];
			end
			if (first || !rd) begin
				last_o = sh;
				count_o++;
			end
			sda_oe_o = hit && (first || !rd) && !(nack_i && !first);
			bitc = 9;
		end else if (busy_o) begin
			if (bitc == 9) begin
				bitc = 0;
				first = 1'b0;
			end
			sda_oe_o = hit && rd && !first && bitc < 8 && !TX[3'(7 - bitc)];
		end
	end
endmodule // twsc_tgt_model
`default_nettype wire

// ---- twsc_two_wire_serial_block.sv ----
// two-wire serial controller and target engine with status and done flag
`timescale 1ns/1ps
`default_nettype none
module twsc_two_wire_serial_block
	import twsc_pkg::*;
#(
	parameter int QTR = QTR_CYCLES,
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic sys_clk_i, // system clock
	input wire logic rstn_i, // sync reset, active low
	input wire logic ctrl_wr_i, // control register write strobe
	input wire twsc_ctrl_s ctrl_i, // control register write value
	input wire logic data_wr_i, // shift data register write strobe
	input wire logic [7:0] data_i, // shift data register write value
	input wire logic [6:0] own_addr_i, // own target address
	output logic done_o, // operation done flag
	output logic [7:0] status_o, // status register
	output logic [7:0] data_o, // shift data register read value
	output logic wr_coll_o, // data write refused while busy
	output logic rx_valid_o, // received byte waiting
	output logic [7:0] rx_data_o, // received byte
	input wire logic rx_ready_i, // received byte taken
	input wire logic scl_i, // clock line level
	output logic scl_o, // clock line drive value
	output logic scl_oe_o, // clock line pulled low
	input wire logic sda_i, // data line level
	output logic sda_o, // data line drive value
	output logic sda_oe_o // data line pulled low
);
	twsc_state_e state_q;
	logic [15:0] div_q;
	logic tick_q, scl_q, sda_q, busy_q;
	logic done_q, set_done_q, start_q, stop_q, enable_q, ack_en_q;
	logic tgt_q, rd_q, addr_q, rep_q, smp_q, tack_q, stall_q, coll_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, status_q;
	logic scl_oe_q, sda_oe_q, push_q, fifo_rdy;
	logic start_det, stop_det, scl_fall, scl_rise;
	logic ctl_tx, tgt_tx, ctl_low, tgt_low, tack, tevt, hold_go;

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign done_o = done_q;
	assign status_o = status_q;
	assign data_o = sh_q;
	assign wr_coll_o = coll_q;

	assign start_det = scl_q && scl_i && sda_q && !sda_i;
	assign stop_det = scl_q && scl_i && !sda_q && sda_i;
	assign scl_fall = scl_q && !scl_i;
	assign scl_rise = !scl_q && scl_i;
	// address bytes always go out; data direction follows the latched bit
	assign ctl_tx = !rd_q || addr_q;
	assign tgt_tx = rd_q && !addr_q;
	assign ctl_low = (bit_q < ACK_BIT) ? (ctl_tx && !sh_q[7])
		: (!ctl_tx && ack_en_q);
	assign tack = addr_q ? (sh_q[7:1] == own_addr_i && ack_en_q) : ack_en_q;
	assign tgt_low = (bit_q < ACK_BIT) ? (tgt_tx && !sh_q[7])
		: (!tgt_tx && tack);
	assign tevt = scl_fall || (stall_q && fifo_rdy);
	assign hold_go = ctrl_wr_i && ctrl_i.done_clr && done_q;

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q == 16'(QTR - 1)) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (start_det) begin
				busy_q <= 1'b1;
			end else if (stop_det) begin
				busy_q <= 1'b0;
			end
		end
	end

	// a set arriving with the software clear wins
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			done_q <= 1'b0;
			enable_q <= 1'b0;
			ack_en_q <= 1'b0;
			coll_q <= 1'b0;
		end else begin
			if (set_done_q) begin
				done_q <= 1'b1;
			end else if (ctrl_wr_i && ctrl_i.done_clr) begin
				done_q <= 1'b0;
			end
			if (ctrl_wr_i) begin
				enable_q <= ctrl_i.enable;
				ack_en_q <= ctrl_i.ack_en;
			end
			if (data_wr_i) begin
				coll_q <= !(done_q || state_q == TWSC_IDLE);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		set_done_q <= 1'b0;
		push_q <= 1'b0;
		if (!rstn_i) begin
			state_q <= TWSC_IDLE;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			status_q <= NO_INFO_CODE;
			sh_q <= 8'h00;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			{tgt_q, rd_q, addr_q, rep_q, smp_q, tack_q, stall_q} <= 7'h00;
		end else begin
			// writes while a byte is on the wire would corrupt it
			if (data_wr_i && (done_q || state_q == TWSC_IDLE)) begin
				sh_q <= data_i;
			end
			// controller roles come from a software start; target roles from a START seen on the bus
			if (ctrl_wr_i && ctrl_i.done_clr && ctrl_i.enable) begin
				start_q <= ctrl_i.start;
				stop_q <= ctrl_i.stop && !ctrl_i.start;
			end
			case (state_q)
			TWSC_IDLE: begin
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
				ph_q <= 2'h0;
				rep_q <= 1'b0;
				stall_q <= 1'b0;
				if (enable_q && start_det) begin
					state_q <= TWSC_SHIFT;
					{tgt_q, addr_q, rd_q} <= 3'b110;
					bit_q <= 4'h0;
				end else if (enable_q && start_q && !busy_q && tick_q) begin
					state_q <= TWSC_START;
					tgt_q <= 1'b0;
				end
			end
			TWSC_START: if (tick_q) begin
				case (ph_q)
				2'h0: begin
					sda_oe_q <= 1'b0;
					ph_q <= 2'h1;
				end
				2'h1: begin
					scl_oe_q <= 1'b0;
					ph_q <= 2'h2;
				end
				2'h2: if (scl_i) begin
					sda_oe_q <= 1'b1;
					ph_q <= 2'h3;
				end
				default: begin
					scl_oe_q <= 1'b1;
					status_q <= rep_q ? RESTART_CODE : START_CODE;
					set_done_q <= 1'b1;
					start_q <= 1'b0;
					{rep_q, addr_q} <= 2'b11;
					bit_q <= 4'h0;
					ph_q <= 2'h0;
					state_q <= TWSC_HOLD;
				end
				endcase
			end
			TWSC_HOLD: begin
				scl_oe_q <= 1'b1;
				if (hold_go && ctrl_i.enable) begin
					ph_q <= 2'h0;
					bit_q <= 4'h0;
					if (tgt_q) begin
						scl_oe_q <= 1'b0;
						sda_oe_q <= rd_q && !sh_q[7];
						state_q <= TWSC_SHIFT;
					end else if (ctrl_i.stop) begin
						state_q <= TWSC_STOP;
					end else if (ctrl_i.start) begin
						state_q <= TWSC_START;
					end else begin
						state_q <= TWSC_SHIFT;
					end
				end
			end
			TWSC_SHIFT: if (tgt_q) begin
				if (stop_det || start_det) begin
					if (!addr_q && stop_det) begin
						status_q <= TGT_STOP_CODE;
						set_done_q <= 1'b1;
					end
					state_q <= start_det ? TWSC_SHIFT : TWSC_IDLE;
					{addr_q, rd_q} <= 2'b10;
					bit_q <= 4'h0;
					sda_oe_q <= 1'b0;
				end else if (scl_rise && bit_q < BYTE_END) begin
					if (bit_q < ACK_BIT) begin
						sh_q <= {sh_q[6:0], sda_i};
					end else begin
						smp_q <= sda_i;
					end
					bit_q <= bit_q + 4'h1;
				end else if (tevt && bit_q == ACK_BIT && !tgt_tx && !addr_q
					&& !fifo_rdy) begin
					scl_oe_q <= 1'b1;
					stall_q <= 1'b1;
				end else if (tevt && bit_q < BYTE_END) begin
					stall_q <= 1'b0;
					scl_oe_q <= 1'b0;
					sda_oe_q <= tgt_low;
					tack_q <= tack;
				end else if (tevt) begin
					sda_oe_q <= 1'b0;
					addr_q <= 1'b0;
					if (addr_q && !tack_q) begin
						state_q <= TWSC_IDLE;
					end else begin
						scl_oe_q <= 1'b1;
						set_done_q <= 1'b1;
						state_q <= TWSC_HOLD;
						if (addr_q) begin
							rd_q <= sh_q[0];
							status_q <= sh_q[0] ? TGT_READ_ADDR_CODE
								: TGT_WRITE_ADDR_CODE;
						end else if (tgt_tx) begin
							status_q <= smp_q ? TGT_TX_NACK_CODE
								: TGT_TX_ACK_CODE;
						end else begin
							push_q <= 1'b1;
							status_q <= tack_q ? TGT_RX_ACK_CODE
								: TGT_RX_NACK_CODE;
						end
					end
				end
			end else if (tick_q) begin
				case (ph_q)
				2'h0: if (!(bit_q == ACK_BIT && !ctl_tx && !fifo_rdy)) begin
					sda_oe_q <= ctl_low;
					ph_q <= 2'h1;
				end
				2'h1: begin
					scl_oe_q <= 1'b0;
					ph_q <= 2'h2;
				end
				2'h2: if (scl_i) begin
					smp_q <= sda_i;
					ph_q <= 2'h3;
					// driving high but the line reads low: another controller won
					if (ctl_tx && bit_q < ACK_BIT && !ctl_low && !sda_i) begin
						sda_oe_q <= 1'b0;
						status_q <= ARB_LOST_CODE;
						set_done_q <= 1'b1;
						start_q <= 1'b0;
						state_q <= TWSC_IDLE;
					end
				end
				default: begin
					scl_oe_q <= 1'b1;
					ph_q <= 2'h0;
					if (bit_q < ACK_BIT) begin
						sh_q <= {sh_q[6:0], smp_q};
						bit_q <= bit_q + 4'h1;
					end else begin
						// sda held while scl falls
						set_done_q <= 1'b1;
						addr_q <= 1'b0;
						state_q <= TWSC_HOLD;
						if (addr_q) begin
							rd_q <= sh_q[0];
							if (sh_q[0]) begin
								status_q <= smp_q ? ADDR_READ_NACK_CODE
									: ADDR_READ_ACKED_CODE;
							end else begin
								status_q <= smp_q ? ADDR_WRITE_NACK_CODE
									: ADDR_WRITE_ACKED_CODE;
							end
						end else if (!rd_q) begin
							status_q <= smp_q ? DATA_WRITE_NACK_CODE
								: DATA_WRITE_ACKED_CODE;
						end else begin
							push_q <= 1'b1;
							status_q <= ack_en_q ? DATA_READ_ACKED_CODE
								: DATA_READ_NACK_CODE;
						end
					end
				end
				endcase
			end
			TWSC_STOP: if (tick_q) begin
				case (ph_q)
				2'h0: begin
					sda_oe_q <= 1'b1;
					ph_q <= 2'h1;
				end
				2'h1: begin
					scl_oe_q <= 1'b0;
					ph_q <= 2'h2;
				end
				2'h2: if (scl_i) begin
					sda_oe_q <= 1'b0;
					ph_q <= 2'h3;
				end
				default: begin
					// no done after a stop; a pending start runs from idle
					stop_q <= 1'b0;
					state_q <= TWSC_IDLE;
				end
				endcase
			end
			default: state_q <= TWSC_IDLE;
			endcase
			if (!enable_q) begin
				state_q <= TWSC_IDLE;
			end
		end
	end

	twsc_fifo #(
		.W(DATA_W),
		.D(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(push_q),
		.in_data_i(sh_q),
		.in_ready_o(fifo_rdy),
		.out_valid_o(rx_valid_o),
		.out_data_o(rx_data_o),
		.out_ready_i(rx_ready_i)
	);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	property p_hold_scl;
		(state_q == TWSC_HOLD && done_q) |-> scl_oe_q;
	endproperty
	a_hold_scl: assert property (p_hold_scl)
		else $error("clock line released while done set");

	property p_suspend;
		(state_q == TWSC_HOLD && done_q && !ctrl_wr_i && enable_q)
			|=> state_q == TWSC_HOLD;
	endproperty
	a_suspend: assert property (p_suspend)
		else $error("transfer resumed without done clear");

	property p_start_code;
		(set_done_q && $past(state_q) == TWSC_START && !$past(rep_q))
			|-> status_q == START_CODE && state_q == TWSC_HOLD;
	endproperty
	a_start_code: assert property (p_start_code)
		else $error("wrong code after start");

	property p_low_bits;
		status_q[2:0] == 3'h0;
	endproperty
	a_low_bits: assert property (p_low_bits)
		else $error("status low bits not zero");

	property p_after_reset;
		$past(!rstn_i) |-> !done_q && !start_q && !stop_q
			&& !scl_oe_q && !sda_oe_q;
	endproperty
	a_after_reset: assert property (disable iff (1'b0) p_after_reset)
		else $error("state not cleared by reset");

	property p_disabled;
		(!enable_q) [*2] |=> !scl_oe_q && !sda_oe_q;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("bus driven while disabled");

	property p_addr_ack;
		(set_done_q && $past(state_q) == TWSC_SHIFT && $past(addr_q)
			&& !$past(tgt_q) && !$past(sh_q[0])
			&& $past(bit_q) == ACK_BIT)
			|-> status_q == ($past(smp_q) ? ADDR_WRITE_NACK_CODE
				: ADDR_WRITE_ACKED_CODE);
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address ack code mismatch");

	property p_data_ack;
		(set_done_q && $past(state_q) == TWSC_SHIFT && !$past(addr_q)
			&& !$past(tgt_q) && !$past(rd_q)
			&& $past(bit_q) == ACK_BIT)
			|-> status_q == ($past(smp_q) ? DATA_WRITE_NACK_CODE
				: DATA_WRITE_ACKED_CODE);
	endproperty
	a_data_ack: assert property (p_data_ack)
		else $error("data ack code mismatch");

	property p_rx_ack_drive;
		(state_q == TWSC_SHIFT && !tgt_q && rd_q && !addr_q
			&& bit_q == ACK_BIT && ph_q == 2'h2) |-> sda_oe_q == ack_en_q;
	endproperty
	a_rx_ack_drive: assert property (p_rx_ack_drive)
		else $error("acknowledge slot drive wrong");

	property p_tx_bit;
		(state_q == TWSC_SHIFT && !tgt_q && ctl_tx && bit_q < ACK_BIT
			&& ph_q == 2'h2) |-> sda_oe_q == !sh_q[7];
	endproperty
	a_tx_bit: assert property (p_tx_bit)
		else $error("sent bit differs from shift register");

	c_start: cover property (set_done_q && status_q == START_CODE);
	c_addr_ack: cover property (set_done_q
		&& status_q == ADDR_WRITE_ACKED_CODE);
	c_data_ack: cover property (set_done_q
		&& status_q == DATA_WRITE_ACKED_CODE);
	c_tgt_addr: cover property (set_done_q
		&& status_q == TGT_WRITE_ADDR_CODE);
endmodule // twsc_two_wire_serial_block
`default_nettype wire
